//--- serial_link_error_monitor_defs.vh
// Constants for the serial link error monitor.
`ifndef SERIAL_LINK_ERROR_MONITOR_DEFS_VH
`define SERIAL_LINK_ERROR_MONITOR_DEFS_VH
`define WORD_BITS 5'h10
`define ADDR_ERROR_FLAGS 10'h1d3
`define ADDR_SERIAL_CONFIG 10'h1c8
`define ADDR_TARGET_SELECT 10'h3ff
`define ERROR_FLAGS_RESET 3'h0
`define SERIAL_CONFIG_RESET 16'h00ff
`define TARGET_SELECT_RESET 16'h0000
`define TARGET_GENERAL_CONFIG 16'h0004
`define CFG_WDOG_MSB 7
`define CFG_WDOG_LSB 0
`define CFG_FRAMED_MODE_BIT 8
`define CFG_IRQ_EN_BIT 9
`define CHECK_PATTERN 13'h1555
`define ERROR_READ_CMD 16'hba61
`define UNDEFINED_WORD 16'h0000
`define CMD_READ_BIT 15
`define CMD_OFFSET_MSB 14
`define CMD_OFFSET_LSB 5
`define CMD_COUNT_MSB 4
`define CMD_COUNT_LSB 0
`define FLAG_WORD_ERROR 0
`define FLAG_FRAME_ERROR 1
`define FLAG_CLOCK_MISSING 2
`define WDOG_LOW_FILL 4'hf
`endif

//--- serial_link_error_monitor.v
// Serial host port protocol engine with error capture and diagnostic answer words.
`timescale 1ns/1ps
`include "serial_link_error_monitor_defs.vh"

// Function
// - Three read-only error flags; upper bits of the error register read zero.
// - Write transfers answer with a word opening with the 13-bit check pattern.
// - Diagnostic word ends with the three low error register bits.
// - First captured error locks the register; later faults are discarded.
// - Interrupt raised on capture when enabled; cleared with the error.
// - Error state accepts only the error-read command word.
// - Error-read returns one word, then leaves error state, releasing interrupt.
// - With general configuration selected, return error code and clear register.
// - Otherwise return undefined word; register kept until read later.
// - Chip select falling while system clock absent sets clock-missing flag.
// - Timed mode: link idle beyond limit during burst is a frame error.
// - Framed mode: word count differing from nonzero command count is error.
// - Framed write overrun stores one extra word before the error.
// - Wrong bit count in a word sets the word error flag.
// - Back-to-back words: bit count checked only at chip select release.
// - Without faults, including after reset, error register reads zero.
// - Every link word is 16 bits long.
// - Timed-mode limit comes from the configuration watchdog field.
module serial_link_error_monitor (
	input wire sys_clk,
	input wire rst_n,
	input wire spi_sclk,
	input wire spi_cs_n,
	input wire spi_mosi,
	input wire cksys_running,
	output reg spi_miso,
	output wire spi_miso_oe_n,
	output wire irq_n,
	output reg mem_wr_strobe,
	output reg [9:0] mem_wr_addr,
	output reg [15:0] mem_wr_data
);

	localparam ST_IDLE = 2'h0;
	localparam ST_DATA = 2'h1;
	localparam ST_ERROR = 2'h2;
	localparam ST_ERR_ANSWER = 2'h3;

	reg [2:0] sclk_sync_reg;
	reg [2:0] cs_sync_reg;
	reg [1:0] mosi_sync_reg;
	reg [1:0] cksys_sync_reg;
	reg [1:0] state_reg;
	reg [4:0] bit_cnt_reg;
	reg [15:0] shift_in_reg;
	reg [15:0] tx_reg;
	reg [15:0] tx_next_reg;
	reg load_pend_reg;
	reg [2:0] error_flags_reg;
	reg [15:0] config_reg;
	reg [15:0] select_reg;
	reg irq_reg;
	reg [9:0] addr_reg;
	reg [4:0] remain_reg;
	reg unlimited_reg;
	reg read_burst_reg;
	reg overrun_reg;
	reg [12:0] idle_cnt_reg;

	wire sclk_rise = sclk_sync_reg[1] & ~sclk_sync_reg[2];
	wire sclk_fall = ~sclk_sync_reg[1] & sclk_sync_reg[2];
	wire cs_fall = ~cs_sync_reg[1] & cs_sync_reg[2];
	wire cs_rise = cs_sync_reg[1] & ~cs_sync_reg[2];
	wire cs_active = ~cs_sync_reg[2];
	wire mosi_s = mosi_sync_reg[1];
	wire framed_mode = config_reg[`CFG_FRAMED_MODE_BIT];
	wire irq_enable = config_reg[`CFG_IRQ_EN_BIT];
	// The watchdog field sets the upper bits of the limit; the fixed low fill keeps a zero
	// field from timing out between the ordinary bit edges of a word.
	wire [12:0] wdog_limit = {config_reg[`CFG_WDOG_MSB:`CFG_WDOG_LSB], 1'b0, `WDOG_LOW_FILL};
	wire [15:0] rx_word = {shift_in_reg[14:0], mosi_s};
	wire word_done = sclk_rise & cs_active & (bit_cnt_reg == (`WORD_BITS - 5'h1));

	reg [2:0] detect;
	reg [2:0] error_flags_next;
	reg [1:0] state_next;
	reg [15:0] tx_next_next;
	reg load_pend_next;
	reg irq_next;
	reg [9:0] addr_next;
	reg [4:0] remain_next;
	reg unlimited_next;
	reg read_burst_next;
	reg overrun_next;
	reg [15:0] config_next;
	reg [15:0] select_next;
	reg wr_strobe_next;
	reg clear_errors;

	// Diagnostic answer shifted out while the master writes.
	function [15:0] diag_word;
		input [2:0] flags;
		begin
			diag_word = {`CHECK_PATTERN, flags};
		end
	endfunction

	// Register read; addresses this block does not own answer the undefined word.
	function [15:0] reg_read;
		input [9:0] addr;
		input [2:0] flags;
		input [15:0] cfg;
		input [15:0] sel;
		begin
			case (addr)
				`ADDR_ERROR_FLAGS: reg_read = {13'h0000, flags};
				`ADDR_SERIAL_CONFIG: reg_read = cfg;
				`ADDR_TARGET_SELECT: reg_read = sel;
				default: reg_read = `UNDEFINED_WORD;
			endcase
		end
	endfunction

	// The pin is driven only while the synchronised select is low, and the first answer
	// bit is loaded at the same edge, so the line never shows a stale bit when enabled.
	assign spi_miso_oe_n = cs_sync_reg[2];
	assign irq_n = ~irq_reg;

	always @* begin
		detect = 3'h0;
		state_next = state_reg;
		tx_next_next = tx_next_reg;
		load_pend_next = load_pend_reg;
		addr_next = addr_reg;
		remain_next = remain_reg;
		unlimited_next = unlimited_reg;
		read_burst_next = read_burst_reg;
		overrun_next = overrun_reg;
		config_next = config_reg;
		select_next = select_reg;
		wr_strobe_next = 1'b0;
		clear_errors = 1'b0;
		irq_next = irq_reg;
		if (cs_fall && !cksys_sync_reg[1])
			detect[`FLAG_CLOCK_MISSING] = 1'b1;
		if (cs_rise && bit_cnt_reg != 5'h00)
			detect[`FLAG_WORD_ERROR] = 1'b1;
		if (word_done) begin
			load_pend_next = 1'b1;
			tx_next_next = diag_word(error_flags_reg);
			case (state_reg)
				ST_IDLE: begin
					addr_next = rx_word[`CMD_OFFSET_MSB:`CMD_OFFSET_LSB];
					remain_next = rx_word[`CMD_COUNT_MSB:`CMD_COUNT_LSB];
					read_burst_next = rx_word[`CMD_READ_BIT];
					overrun_next = 1'b0;
					unlimited_next = (rx_word[`CMD_COUNT_MSB:`CMD_COUNT_LSB] == 5'h00);
					if (!unlimited_next || framed_mode)
						state_next = ST_DATA;
					if (rx_word[`CMD_READ_BIT] && state_next == ST_DATA) begin
						tx_next_next = reg_read(addr_next, error_flags_reg, config_reg,
							select_reg);
						if (addr_next == `ADDR_ERROR_FLAGS)
							clear_errors = 1'b1;
					end
				end
				ST_DATA: begin
					if (!read_burst_reg) begin
						if (addr_reg == `ADDR_SERIAL_CONFIG)
							config_next = rx_word;
						else if (addr_reg == `ADDR_TARGET_SELECT)
							select_next = rx_word;
						else
							wr_strobe_next = 1'b1;
					end
					addr_next = addr_reg + 10'h001;
					if (!unlimited_reg) begin
						if (remain_reg == 5'h00) begin
							detect[`FLAG_FRAME_ERROR] = 1'b1;
							overrun_next = 1'b1;
						end else begin
							remain_next = remain_reg - 5'h01;
							if (remain_next == 5'h00 && !framed_mode)
								state_next = ST_IDLE;
						end
					end
					if (read_burst_reg && state_next == ST_DATA) begin
						tx_next_next = reg_read(addr_next, error_flags_reg, config_reg,
							select_reg);
						if (addr_next == `ADDR_ERROR_FLAGS)
							clear_errors = 1'b1;
					end
				end
				ST_ERROR: begin
					if (rx_word == `ERROR_READ_CMD) begin
						state_next = ST_ERR_ANSWER;
						if (select_reg == `TARGET_GENERAL_CONFIG) begin
							tx_next_next = {13'h0000, error_flags_reg};
							clear_errors = 1'b1;
						end else begin
							tx_next_next = `UNDEFINED_WORD;
						end
					end
				end
				default: begin
					state_next = ST_IDLE;
					irq_next = 1'b0;
				end
			endcase
		end
		// A burst that has used up its count also ends at chip select release, so a
		// switch from framed to timed mode inside the burst cannot leave it hanging
		// and later trip the watchdog.
		if (cs_rise && state_reg == ST_DATA && (framed_mode || remain_reg == 5'h00)) begin
			state_next = ST_IDLE;
			if (framed_mode && !unlimited_reg && remain_reg != 5'h00 && !overrun_reg)
				detect[`FLAG_FRAME_ERROR] = 1'b1;
		end
		if (state_reg == ST_DATA && !framed_mode && idle_cnt_reg > wdog_limit)
			detect[`FLAG_FRAME_ERROR] = 1'b1;
		// A detection in the clearing cycle is captured, so no fault is lost at the clear.
		error_flags_next = error_flags_reg;
		if (clear_errors) begin
			error_flags_next = `ERROR_FLAGS_RESET;
			irq_next = 1'b0;
		end
		if (error_flags_next == 3'h0 && detect != 3'h0) begin
			error_flags_next = detect;
			state_next = ST_ERROR;
			if (irq_enable)
				irq_next = 1'b1;
		end
	end

	// Pins from the master pass two flip-flops; the third stage of the clock only serves edge
	// detection, that of the select also gives the active level and the output enable.
	always @(posedge sys_clk) begin
		if (!rst_n) begin
			sclk_sync_reg <= 3'h0;
			cs_sync_reg <= 3'h7;
			mosi_sync_reg <= 2'h0;
			cksys_sync_reg <= 2'h0;
		end else begin
			sclk_sync_reg <= {sclk_sync_reg[1:0], spi_sclk};
			cs_sync_reg <= {cs_sync_reg[1:0], spi_cs_n};
			mosi_sync_reg <= {mosi_sync_reg[0], spi_mosi};
			cksys_sync_reg <= {cksys_sync_reg[0], cksys_running};
		end
	end

	always @(posedge sys_clk) begin
		if (!rst_n) begin
			state_reg <= ST_IDLE;
			bit_cnt_reg <= 5'h00;
			shift_in_reg <= 16'h0000;
			tx_reg <= 16'h0000;
			tx_next_reg <= 16'h0000;
			load_pend_reg <= 1'b0;
			error_flags_reg <= `ERROR_FLAGS_RESET;
			config_reg <= `SERIAL_CONFIG_RESET;
			select_reg <= `TARGET_SELECT_RESET;
			irq_reg <= 1'b0;
			addr_reg <= 10'h000;
			remain_reg <= 5'h00;
			unlimited_reg <= 1'b0;
			read_burst_reg <= 1'b0;
			overrun_reg <= 1'b0;
			idle_cnt_reg <= 13'h0000;
			spi_miso <= 1'b0;
			mem_wr_strobe <= 1'b0;
			mem_wr_addr <= 10'h000;
			mem_wr_data <= 16'h0000;
		end else begin
			state_reg <= state_next;
			error_flags_reg <= error_flags_next;
			config_reg <= config_next;
			select_reg <= select_next;
			irq_reg <= irq_next;
			addr_reg <= addr_next;
			remain_reg <= remain_next;
			unlimited_reg <= unlimited_next;
			read_burst_reg <= read_burst_next;
			overrun_reg <= overrun_next;
			tx_next_reg <= tx_next_next;
			mem_wr_strobe <= wr_strobe_next;
			if (wr_strobe_next) begin
				mem_wr_addr <= addr_reg;
				mem_wr_data <= rx_word;
			end
			if (cs_fall || cs_rise)
				bit_cnt_reg <= 5'h00;
			else if (sclk_rise && cs_active) begin
				shift_in_reg <= rx_word;
				if (word_done)
					bit_cnt_reg <= 5'h00;
				else
					bit_cnt_reg <= bit_cnt_reg + 5'h01;
			end
			// The counter saturates, so a long pause cannot wrap back below the limit.
			if (sclk_rise || sclk_fall || cs_fall || state_next != ST_DATA)
				idle_cnt_reg <= 13'h0000;
			else if (idle_cnt_reg != 13'h1fff)
				idle_cnt_reg <= idle_cnt_reg + 13'h0001;
			// The first answer bit must be on the line before the first rising edge.
			if (cs_fall) begin
				tx_reg <= diag_word(error_flags_next);
				spi_miso <= 1'b1;
				load_pend_reg <= 1'b0;
			end else if (sclk_fall && cs_active) begin
				if (load_pend_next) begin
					tx_reg <= tx_next_next;
					spi_miso <= tx_next_next[15];
					load_pend_reg <= 1'b0;
				end else begin
					tx_reg <= {tx_reg[14:0], 1'b0};
					spi_miso <= tx_reg[14];
					load_pend_reg <= load_pend_next;
				end
			end else begin
				load_pend_reg <= load_pend_next;
			end
		end
	end

endmodule // serial_link_error_monitor

//--- sle_assertions.sv
// Port assertions for the serial link error monitor.
`timescale 1ns/1ps
module sle_assertions (
	input wire sys_clk,
	input wire rst_n,
	input wire spi_sclk,
	input wire spi_cs_n,
	input wire spi_mosi,
	input wire cksys_running,
	input wire spi_miso,
	input wire spi_miso_oe_n,
	input wire irq_n,
	input wire mem_wr_strobe,
	input wire [9:0] mem_wr_addr,
	input wire [15:0] mem_wr_data
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	a_oe_released: assert property (spi_cs_n [*5] |-> spi_miso_oe_n)
		else $error("miso driven while deselected");
	a_oe_driving: assert property ((!spi_cs_n) [*5] |-> !spi_miso_oe_n)
		else $error("miso not driven while selected");
	a_first_bit: assert property ($fell(spi_miso_oe_n) |-> ##[0:1] spi_miso)
		else $error("answer word does not open with one");
	a_miso_steady: assert property (spi_sclk [*2] |-> $stable(spi_miso))
		else $error("miso moved while link clock high");
	a_strobe_pulse: assert property (mem_wr_strobe |=> !mem_wr_strobe)
		else $error("write strobe longer than one cycle");
	a_wr_held: assert property (!mem_wr_strobe |-> $stable(mem_wr_addr) && $stable(mem_wr_data))
		else $error("write address or data moved without a strobe");
	a_strobe_in_frame: assert property (mem_wr_strobe |-> !spi_miso_oe_n)
		else $error("write strobe outside a transfer");
	a_irq_release: assert property ($rose(irq_n) |-> !spi_miso_oe_n)
		else $error("interrupt released outside a transfer");
	a_reset_idle: assert property ($rose(rst_n) |-> irq_n && spi_miso_oe_n && !mem_wr_strobe)
		else $error("outputs not idle after reset");
endmodule // sle_assertions

bind serial_link_error_monitor sle_assertions sle_assertions_i (
	.sys_clk(sys_clk), .rst_n(rst_n), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
	.spi_mosi(spi_mosi), .cksys_running(cksys_running), .spi_miso(spi_miso),
	.spi_miso_oe_n(spi_miso_oe_n), .irq_n(irq_n), .mem_wr_strobe(mem_wr_strobe),
	.mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data));

//--- host_model.sv
// Host controller model acting as master on the serial link.
`timescale 1ns/1ps
module host_model (
	output logic spi_sclk,
	output logic spi_cs_n,
	output logic spi_mosi,
	input logic spi_miso
);
	initial begin
		spi_sclk = 1'b0;
		spi_cs_n = 1'b1;
		spi_mosi = 1'b0;
	end
	task automatic frame(input logic open);
		#400 spi_cs_n = !open;
		#400;
	endtask
	task automatic xfer(input logic [15:0] w, input int nb, output logic [15:0] r);
		r = 16'h0000;
		for (int i = 15; i > 15 - nb; i--) begin
			spi_mosi = w[i];
			#200 spi_sclk = 1'b1;
			r = {r[14:0], spi_miso};
			#200 spi_sclk = 1'b0;
		end
		// A released data line must not keep looking valid.
		spi_mosi = ~spi_mosi;
	endtask
endmodule // host_model

//--- serial_link_error_monitor_tb_top.sv
// Self-checking bench for the serial link error monitor.
`timescale 1ns/1ps
module serial_link_error_monitor_tb_top;
	logic sys_clk;
	logic rst_n;
	logic cksys_running;
	wire spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe_n, irq_n, mem_wr_strobe;
	// A released data-out line shows the inverse of the last bit, so a late sample fails.
	wire miso_line = spi_miso_oe_n ? ~spi_miso : spi_miso;
	wire [9:0] mem_wr_addr;
	wire [15:0] mem_wr_data;
	logic [15:0] r;
	logic [15:0] wd;
	logic [9:0] wa;
	logic [2:0] ef = 3'h0;
	int n_mismatch = 0;
	int n_checks = 0;
	int nw = 0;
	initial sys_clk = 1'b0;
	always #25 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		if (mem_wr_strobe === 1'b1) begin
			wa <= mem_wr_addr;
			wd <= mem_wr_data;
			nw <= nw + 1;
		end
	end
	serial_link_error_monitor serial_link_error_monitor_i (.sys_clk(sys_clk), .rst_n(rst_n),
		.spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
		.cksys_running(cksys_running), .spi_miso(spi_miso), .spi_miso_oe_n(spi_miso_oe_n),
		.irq_n(irq_n), .mem_wr_strobe(mem_wr_strobe), .mem_wr_addr(mem_wr_addr),
		.mem_wr_data(mem_wr_data));
	host_model host_model_i (.spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
		.spi_miso(miso_line));
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#2;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cmd(input logic [15:0] c);
		host_model_i.frame(1'b1);
		host_model_i.xfer(c, 16, r);
		chk(r, {13'h1555, ef});
	endtask
	task automatic wr(input logic [9:0] a, input logic [15:0] d);
		cmd({1'b0, a, 5'h01});
		host_model_i.xfer(d, 16, r);
		chk(r, {13'h1555, ef});
		host_model_i.frame(1'b0);
	endtask
	task automatic rd_reg(input logic [9:0] a, input logic [15:0] e);
		cmd({1'b1, a, 5'h01});
		host_model_i.xfer(16'h0000, 16, r);
		host_model_i.frame(1'b0);
		chk(r, e);
	endtask
	// Error flags read; the same command word is the recovery command.
	task automatic rd(input logic [15:0] e);
		rd_reg(10'h1d3, e);
	endtask
	task automatic no_clock;
		tick(1);
		cksys_running = 1'b0;
		host_model_i.frame(1'b1);
		host_model_i.frame(1'b0);
		tick(1);
		cksys_running = 1'b1;
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		rst_n = 1'b0;
		cksys_running = 1'b1;
		tick(3);
		rst_n = 1'b1;
		tick(3);
		rd(16'h0000);
		wr(10'h1c8, 16'h02ff);
		rd_reg(10'h1c8, 16'h02ff);
		wr(10'h100, 16'h1234);
		chk({6'h00, wa}, 16'h0100);
		chk(wd, 16'h1234);
		host_model_i.frame(1'b1);
		host_model_i.xfer(16'h0000, 16, r);
		chk(r, {13'h1555, ef});
		host_model_i.xfer(16'hffff, 12, r);
		host_model_i.frame(1'b0);
		ef = 3'h1;
		chk({15'h0000, irq_n}, 16'h0000);
		no_clock();
		nw = 0;
		wr(10'h100, 16'h5555);
		chk(nw[15:0], 16'h0000);
		rd(16'h0000);
		chk({15'h0000, irq_n}, 16'h0001);
		rd(16'h0001);
		ef = 3'h0;
		wr(10'h3ff, 16'h0004);
		rd_reg(10'h3ff, 16'h0004);
		no_clock();
		ef = 3'h4;
		chk({15'h0000, irq_n}, 16'h0000);
		rd(16'h0004);
		ef = 3'h0;
		chk({15'h0000, irq_n}, 16'h0001);
		rd(16'h0000);
		wr(10'h1c8, 16'h0300);
		nw = 0;
		cmd(16'h2001);
		host_model_i.xfer(16'h0a0a, 16, r);
		host_model_i.xfer(16'h0b0b, 16, r);
		host_model_i.frame(1'b0);
		ef = 3'h2;
		chk(nw[15:0], 16'h0002);
		chk(wd, 16'h0b0b);
		rd(16'h0002);
		ef = 3'h0;
		wr(10'h1c8, 16'h0200);
		cmd(16'h2002);
		host_model_i.xfer(16'h0c0c, 16, r);
		tick(40);
		host_model_i.frame(1'b0);
		ef = 3'h2;
		rd(16'h0002);
		test_done();
	end
	initial begin
		#3000000;
		n_mismatch++;
		test_done();
	end
endmodule // serial_link_error_monitor_tb_top
